// File: rtl/sas_pkg.sv
// Purpose: shared constants, types and code tables of the converter sequencer
// Assumes: 200 MHz system clock, registers on an AXI4-Lite slave
// Notes:   one aligned 32-bit word per register, data in the low byte
package sas_pkg;
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TCY_NS        = 20;
    localparam int TCY_CYC       = (TCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RC_TAD_NS     = 1200;
    localparam int RC_TAD_CYC    = (RC_TAD_NS * 1000) / CLK_PERIOD_PS;
    localparam int CONV_TADS     = 11;
    localparam int GAP_TADS      = 2;
    localparam int RES_BITS      = 10;
    // register offsets
    localparam logic [7:0] OFS_MAIN  = 8'h00;
    localparam logic [7:0] OFS_REFS  = 8'h04;
    localparam logic [7:0] OFS_FT    = 8'h08;
    localparam logic [7:0] OFS_RES_H = 8'h0C;
    localparam logic [7:0] OFS_RES_L = 8'h10;
    localparam logic [7:0] OFS_FLAG  = 8'h14;
    // field positions
    localparam int MAIN_EN_BIT   = 0;
    localparam int MAIN_BUSY_BIT = 1;
    localparam int MAIN_CH_LSB   = 2;
    localparam int REFS_VREF_LSB = 4;
    localparam int FT_JUST_BIT   = 7;
    localparam int FT_ACQ_LSB    = 3;
    localparam int FT_CS_LSB     = 0;
    localparam int FLAG_DONE_BIT = 0;
    // reset values
    localparam logic [7:0] RST_MAIN = 8'h00;
    localparam logic [7:0] RST_REFS = 8'h00;
    localparam logic [7:0] RST_FT   = 8'h00;
    // internal RC clock select: low two bits both set
    localparam logic [1:0] CS_RC_LOW = 2'b11;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_GAP} sas_state_t;

    // system clocks per conversion-clock period
    function automatic logic [6:0] tad_div(input logic [2:0] s);
        case (s)
            3'b000:  tad_div = 7'h02;
            3'b100:  tad_div = 7'h04;
            3'b001:  tad_div = 7'h08;
            3'b101:  tad_div = 7'h10;
            3'b010:  tad_div = 7'h20;
            3'b110:  tad_div = 7'h40;
            default: tad_div = 7'h02;
        endcase
    endfunction

    // conversion-clock periods of automatic acquisition
    function automatic logic [4:0] acq_tads(input logic [2:0] c);
        case (c)
            3'b001:  acq_tads = 5'h02;
            3'b010:  acq_tads = 5'h04;
            3'b011:  acq_tads = 5'h06;
            3'b100:  acq_tads = 5'h08;
            3'b101:  acq_tads = 5'h0C;
            3'b110:  acq_tads = 5'h10;
            3'b111:  acq_tads = 5'h14;
            default: acq_tads = 5'h00;
        endcase
    endfunction
endpackage

// File: rtl/sas_tad_if.sv
// Purpose: link between the sequencer and its conversion-clock generator
// Assumes: single clock domain
// Notes:   tad is a one-cycle enable, one per conversion-clock period
`timescale 1ns/100ps
interface sas_tad_if;
    logic       run;
    logic [2:0] sel;
    logic       sleep;
    logic       tad;
    modport ctl (output run, output sel, output sleep, input tad);
    modport gen (input run, input sel, input sleep, output tad);
endinterface

// File: rtl/sas_tad_gen.sv
// Purpose: conversion-clock enable divider with internal RC source option
// Assumes: RC source modelled as a fixed division of the system clock
// Notes:   RC start is held off one instruction cycle; system dividers stop in sleep
`timescale 1ns/100ps
module sas_tad_gen
    import sas_pkg::*;
#(
    parameter int RC_DIV = RC_TAD_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // sequencer side
    sas_tad_if.gen    tif
);
    if (RC_DIV < 2 || RC_DIV > 65535) begin : g_chk
        $error("RC_DIV out of range");
    end

    logic [15:0] cnt_reg;
    logic [15:0] dly_reg;
    logic        run_d_reg;
    logic [15:0] period;
    logic        rc_sel;
    logic        halt;
    logic        rise;

    assign rc_sel  = tif.sel[1:0] == CS_RC_LOW;
    assign period  = rc_sel ? 16'(RC_DIV) : {9'h000, tad_div(tif.sel)};
    // oscillator-derived clocks stop while the device sleeps
    assign halt    = tif.sleep & ~rc_sel;
    assign rise    = tif.run & ~run_d_reg;
    assign tif.tad = tif.run & ~rise & (dly_reg == 16'h0000) & ~halt
                   & (cnt_reg == period - 16'h0001);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_reg   <= 16'h0000;
            dly_reg   <= 16'h0000;
            run_d_reg <= 1'b0;
        end else begin
            run_d_reg <= tif.run;
            if (!tif.run) begin
                cnt_reg <= 16'h0000;
                dly_reg <= 16'h0000;
            end else if (rise) begin
                cnt_reg <= 16'h0000;
                dly_reg <= rc_sel ? 16'(TCY_CYC) : 16'h0000;
            end else if (dly_reg != 16'h0000) begin
                dly_reg <= dly_reg - 16'h0001;
            end else if (!halt) begin
                cnt_reg <= tif.tad ? 16'h0000 : cnt_reg + 16'h0001;
            end
        end
    end
endmodule

// File: rtl/sas_top.sv
// Purpose: 10-bit successive-approximation converter control and sequencer
// Assumes: comparator answers CMP_I during the conversion-clock period of each trial
// Notes:   registers on AXI4-Lite, one word each, data in bits 7:0
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module sas_top
    import sas_pkg::*;
#(
    parameter int RC_DIV = RC_TAD_CYC
) (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        SRST_I,
    // AXI4-Lite write
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output wire logic        S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output wire logic        S_AXI_WREADY_O,
    output wire logic [1:0]  S_AXI_BRESP_O,
    output wire logic        S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    // AXI4-Lite read
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output wire logic        S_AXI_ARREADY_O,
    output wire logic [31:0] S_AXI_RDATA_O,
    output wire logic [1:0]  S_AXI_RRESP_O,
    output wire logic        S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    // analog front end
    output wire logic        SAMPLE_O,
    output wire logic [3:0]  CHANNEL_O,
    output wire logic [1:0]  VREF_SEL_O,
    output wire logic [3:0]  PORT_CFG_O,
    output wire logic [9:0]  DAC_CODE_O,
    input  wire logic        CMP_I,
    // system
    input  wire logic        TRIG_I,
    input  wire logic        SLEEP_I,
    output wire logic        DONE_FLAG_O
);
    sas_tad_if tif ();

    // bus state
    logic        aw_full_reg;
    logic [7:0]  awaddr_reg;
    logic        w_full_reg;
    logic [7:0]  wdata_reg;
    logic        wstrb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [7:0]  raddr_reg;
    // registers
    logic        en_reg;
    logic        busy_reg;
    logic [3:0]  ch_reg;
    logic [5:0]  refs_reg;
    logic        just_reg;
    logic [2:0]  acq_reg;
    logic [2:0]  cs_reg;
    logic [7:0]  res_hi_reg;
    logic [7:0]  res_lo_reg;
    logic        flag_reg;
    // sequencer
    sas_state_t  state_reg;
    sas_state_t  state_next;
    logic [4:0]  phase_reg;
    logic [9:0]  sar_reg;
    logic        en_next;
    logic        busy_next;

    // bus decode
    logic        wr_fire;
    logic        wr_ok;
    logic        wr_main;
    logic        wr_refs;
    logic        wr_ft;
    logic        wr_res_h;
    logic        wr_res_l;
    logic        wr_flag;
    logic        ar_fire;
    logic        rd_ok;
    logic [7:0]  rd_byte;
    logic        tad;
    logic        conv_done;
    logic        acq_end;
    logic        gap_end;
    logic        start_sw;
    logic        abort_sw;
    logic        trig_ok;
    logic [9:0]  trial_bit;
    logic [7:0]  just_hi;
    logic [7:0]  just_lo;

    assign wr_fire  = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wr_ok    = awaddr_reg == OFS_MAIN || awaddr_reg == OFS_REFS
                   || awaddr_reg == OFS_FT || awaddr_reg == OFS_RES_H
                   || awaddr_reg == OFS_RES_L || awaddr_reg == OFS_FLAG;
    assign wr_main  = wr_fire & wstrb_reg & (awaddr_reg == OFS_MAIN);
    assign wr_refs  = wr_fire & wstrb_reg & (awaddr_reg == OFS_REFS);
    assign wr_ft    = wr_fire & wstrb_reg & (awaddr_reg == OFS_FT);
    assign wr_res_h = wr_fire & wstrb_reg & (awaddr_reg == OFS_RES_H);
    assign wr_res_l = wr_fire & wstrb_reg & (awaddr_reg == OFS_RES_L);
    assign wr_flag  = wr_fire & wstrb_reg & (awaddr_reg == OFS_FLAG);
    assign ar_fire  = S_AXI_ARVALID_I & ~rvalid_reg;
    assign rd_ok    = S_AXI_ARADDR_I == OFS_MAIN || S_AXI_ARADDR_I == OFS_REFS
                   || S_AXI_ARADDR_I == OFS_FT || S_AXI_ARADDR_I == OFS_RES_H
                   || S_AXI_ARADDR_I == OFS_RES_L || S_AXI_ARADDR_I == OFS_FLAG;
    assign rd_byte  = (S_AXI_ARADDR_I == OFS_MAIN)  ? {2'b00, ch_reg, busy_reg, en_reg} :
                      (S_AXI_ARADDR_I == OFS_REFS)  ? {2'b00, refs_reg} :
                      (S_AXI_ARADDR_I == OFS_FT)    ? {just_reg, 1'b0, acq_reg, cs_reg} :
                      (S_AXI_ARADDR_I == OFS_RES_H) ? res_hi_reg :
                      (S_AXI_ARADDR_I == OFS_RES_L) ? res_lo_reg :
                      (S_AXI_ARADDR_I == OFS_FLAG)  ? {7'h00, flag_reg} : 8'h00;

    assign S_AXI_AWREADY_O = ~aw_full_reg & ~bvalid_reg;
    assign S_AXI_WREADY_O  = ~w_full_reg & ~bvalid_reg;
    assign S_AXI_BVALID_O  = bvalid_reg;
    assign S_AXI_BRESP_O   = bresp_reg;
    assign S_AXI_ARREADY_O = ~rvalid_reg;
    assign S_AXI_RVALID_O  = rvalid_reg;
    assign S_AXI_RDATA_O   = rdata_reg;
    assign S_AXI_RRESP_O   = rresp_reg;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            aw_full_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
            w_full_reg  <= 1'b0;
            wdata_reg   <= 8'h00;
            wstrb_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_full_reg <= 1'b1;
                awaddr_reg  <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_full_reg <= 1'b1;
                wdata_reg  <= S_AXI_WDATA_I[7:0];
                wstrb_reg  <= S_AXI_WSTRB_I[0];
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
            raddr_reg  <= 8'h00;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h00_0000, rd_byte};
            rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            raddr_reg  <= S_AXI_ARADDR_I;
        end else if (S_AXI_RREADY_I) begin
            rvalid_reg <= 1'b0;
        end
    end

    // start, abort and trigger
    assign en_next  = wr_main ? wdata_reg[MAIN_EN_BIT] : en_reg;
    // a start in the same write that turns the module on is not honoured
    assign start_sw = wr_main & wdata_reg[MAIN_BUSY_BIT] & en_reg;
    assign abort_sw = wr_main & ~wdata_reg[MAIN_BUSY_BIT] & busy_reg;
    assign trig_ok  = TRIG_I & en_reg;

    always_comb begin
        busy_next = busy_reg;
        if (conv_done || abort_sw) begin
            busy_next = 1'b0;
        end
        if (start_sw || trig_ok) begin
            busy_next = 1'b1;
        end
        if (!en_next) begin
            busy_next = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            en_reg   <= RST_MAIN[MAIN_EN_BIT];
            busy_reg <= RST_MAIN[MAIN_BUSY_BIT];
            ch_reg   <= RST_MAIN[MAIN_CH_LSB +: 4];
            refs_reg <= RST_REFS[5:0];
            just_reg <= RST_FT[FT_JUST_BIT];
            acq_reg  <= RST_FT[FT_ACQ_LSB +: 3];
            cs_reg   <= RST_FT[FT_CS_LSB +: 3];
            flag_reg <= 1'b0;
        end else begin
            en_reg   <= en_next;
            busy_reg <= busy_next;
            if (wr_main) begin
                ch_reg <= wdata_reg[MAIN_CH_LSB +: 4];
            end
            if (wr_refs) begin
                refs_reg <= wdata_reg[5:0];
            end
            if (wr_ft) begin
                just_reg <= wdata_reg[FT_JUST_BIT];
                acq_reg  <= wdata_reg[FT_ACQ_LSB +: 3];
                cs_reg   <= wdata_reg[FT_CS_LSB +: 3];
            end
            // a completion in the clearing cycle wins
            if (conv_done) begin
                flag_reg <= 1'b1;
            end else if (wr_flag && wdata_reg[FLAG_DONE_BIT]) begin
                flag_reg <= 1'b0;
            end
        end
    end

    // result pair has no reset term
    assign just_hi = just_reg ? {6'h00, sar_reg[9:8]} : sar_reg[9:2];
    assign just_lo = just_reg ? sar_reg[7:0] : {sar_reg[1:0], 6'h00};

    always_ff @(posedge CLK_I) begin
        if (conv_done) begin
            res_hi_reg <= just_hi;
            res_lo_reg <= just_lo;
        end else begin
            if (wr_res_h) begin
                res_hi_reg <= wdata_reg;
            end
            if (wr_res_l) begin
                res_lo_reg <= wdata_reg;
            end
        end
    end

    // sequencer
    assign tif.run   = state_reg != ST_IDLE;
    assign tif.sel   = cs_reg;
    assign tif.sleep = SLEEP_I;
    assign tad       = tif.tad;

    assign conv_done = state_reg == ST_CONV && tad
                    && phase_reg == 5'(CONV_TADS - 1);
    assign acq_end   = tad && phase_reg == acq_tads(acq_reg) - 5'h01;
    assign gap_end   = tad && phase_reg == 5'(GAP_TADS - 1);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (busy_reg) begin
                    state_next = (acq_reg == 3'b000) ? ST_CONV : ST_ACQ;
                end
            end
            ST_ACQ: begin
                if (!busy_next) begin
                    state_next = ST_GAP;
                end else if (acq_end) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done || !busy_next) begin
                    state_next = ST_GAP;
                end
            end
            ST_GAP: begin
                if (gap_end) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (!en_next) begin
            state_next = ST_IDLE;
        end
    end

    // trial bit under test in the current conversion-clock period
    assign trial_bit = (state_reg == ST_CONV && phase_reg < 5'(RES_BITS))
                     ? (10'h200 >> phase_reg) : 10'h000;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_reg <= ST_IDLE;
            phase_reg <= 5'h00;
            sar_reg   <= 10'h000;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                phase_reg <= 5'h00;
            end else if (tad) begin
                phase_reg <= phase_reg + 5'h01;
            end
            if (state_reg != ST_CONV && state_next == ST_CONV) begin
                sar_reg <= 10'h000;
            end else if (tad && trial_bit != 10'h000 && CMP_I) begin
                sar_reg <= sar_reg | trial_bit;
            end
        end
    end

    sas_tad_gen #(
        .RC_DIV (RC_DIV)
    ) u_tad (
        .clk_i  (CLK_I),
        .srst_i (SRST_I),
        .tif    (tif)
    );

    assign SAMPLE_O    = en_reg & (state_reg == ST_IDLE || state_reg == ST_ACQ);
    assign CHANNEL_O   = ch_reg;
    assign VREF_SEL_O  = refs_reg[REFS_VREF_LSB +: 2];
    assign PORT_CFG_O  = refs_reg[3:0];
    assign DAC_CODE_O  = sar_reg | trial_bit;
    assign DONE_FLAG_O = flag_reg;

    // checks
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    a_done_clears_busy: assert property (conv_done |=> !busy_reg && flag_reg)
        else $error("completion did not clear busy and set flag");
    a_result_justify: assert property (conv_done && just_reg |=>
        res_hi_reg[7:2] == 6'h00 && {res_hi_reg[1:0], res_lo_reg} == $past(sar_reg))
        else $error("right justified result wrong");
    a_left_justify: assert property (conv_done && !just_reg |=>
        res_lo_reg[5:0] == 6'h00 && {res_hi_reg, res_lo_reg[7:6]} == $past(sar_reg))
        else $error("left justified result wrong");
    a_bit6_zero: assert property (rvalid_reg && raddr_reg == OFS_FT |-> !rdata_reg[6])
        else $error("format register bit 6 read as one");
    a_acq_length: assert property (state_reg == ST_ACQ && state_next == ST_CONV
        |-> tad && phase_reg == acq_tads(acq_reg) - 5'h01)
        else $error("acquisition length wrong");
    a_manual_start: assert property (state_reg == ST_IDLE && busy_reg && en_next
        && acq_reg == 3'b000 |=> state_reg == ST_CONV && !SAMPLE_O)
        else $error("manual start did not convert at once");
    a_conv_eleven: assert property (state_reg == ST_CONV && state_next == ST_GAP
        && busy_next |-> phase_reg == 5'h0A && tad)
        else $error("conversion not eleven periods");
    a_gap_two: assert property (state_reg == ST_GAP && state_next == ST_IDLE && en_next
        |-> phase_reg == 5'h01 && tad)
        else $error("post-conversion gap not two periods");
    a_hold_open: assert property (state_reg == ST_CONV |-> !SAMPLE_O)
        else $error("input connected during conversion");
    a_resample: assert property (state_reg == ST_GAP && state_next == ST_IDLE
        && en_next |=> SAMPLE_O)
        else $error("sampling not resumed after gap");
    a_abort_keeps: assert property (state_reg == ST_CONV && abort_sw && !conv_done
        |=> $stable(res_hi_reg) && $stable(res_lo_reg)
        && state_reg == (en_reg ? ST_GAP : ST_IDLE))
        else $error("abort changed result");
    a_trig_ignored: assert property (TRIG_I && !en_reg && !wr_main |=> !busy_reg)
        else $error("trigger honoured while disabled");
    a_busy_through: assert property (state_reg == ST_ACQ && state_next == ST_CONV
        |=> busy_reg)
        else $error("busy dropped between phases");
    a_reset_off: assert property (disable iff (1'b0) SRST_I
        |=> !en_reg && !busy_reg && state_reg == ST_IDLE)
        else $error("reset left converter running");
endmodule

// File: sim/sas_cmp_model.sv
// Purpose: sample-and-hold and comparator model facing the sequencer
// Assumes: ideal comparator, held level tracks the input while sampling
// Notes:   held level freezes once the holding capacitor is disconnected
`timescale 1ns/100ps
module sas_cmp_model (
    // clock
    input  wire logic       clk_i,
    // analog side
    input  wire logic       sample_i,
    input  wire logic [9:0] vin_i,
    input  wire logic [9:0] dac_i,
    output wire logic       cmp_o
);
    logic [9:0] held_reg;
    always @(posedge clk_i) begin
        if (sample_i) begin
            held_reg <= vin_i;
        end
    end
    assign cmp_o = (held_reg >= dac_i);
endmodule

// File: sim/tb_sar_adc_sequencer.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: comparator model on the analog side, register access over AXI4-Lite
// Notes:   read and write answers are compared against queued notes
`timescale 1ns/100ps
module tb_sar_adc_sequencer
    import sas_pkg::*;
;
    localparam int RCD = 4;
    logic        clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
    logic        arv = 1'b0, rry = 1'b0, trig = 1'b0, slp = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00, ft, eh, el;
    logic [31:0] wd = 32'h0, rnd = 32'h267EEE12;
    logic [9:0]  vin = 10'h000;
    logic [3:0]  ch;
    logic [2:0]  q, c;
    wire  logic  awr, wrd, bv, arr, rv, smp, cmp, done;
    wire  logic [1:0]  br, rr, vref;
    wire  logic [3:0]  chn, pcfg;
    wire  logic [9:0]  dac;
    wire  logic [31:0] rd;
    int          error_cnt = 0, samples_checked = 0, n, t;
    logic [33:0] rq[$];
    logic [1:0]  wq[$];
    int          per[8] = '{2, 8, 32, RCD, 4, 16, 64, RCD};
    int          acq[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

    always #2.5 clk = ~clk;

    sas_top #(.RC_DIV(RCD)) i_sas_top (
        .CLK_I(clk), .SRST_I(srst),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
        .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
        .SAMPLE_O(smp), .CHANNEL_O(chn), .VREF_SEL_O(vref), .PORT_CFG_O(pcfg),
        .DAC_CODE_O(dac), .CMP_I(cmp), .TRIG_I(trig), .SLEEP_I(slp), .DONE_FLAG_O(done));
    sas_cmp_model i_sas_cmp_model (
        .clk_i(clk), .sample_i(smp), .vin_i(vin), .dac_i(dac), .cmp_o(cmp));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        int k = 0;
        wq.push_back(r);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv && k < 100);
        chk("bvalid", 1'b1, bv);
        bry <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        int k = 0;
        rq.push_back({r, 24'h0, d});
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (arr) arv <= 1'b0;
        end while (!rv && k < 100);
        chk("rvalid", 1'b1, rv);
        rry <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wdone();
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (done !== 1'b1 && n < 5000);
        @(posedge clk);
    endtask
    task automatic pulse();
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // answers are matched against the oldest note
    always @(posedge clk) begin
        if (rv && rry) chk("rdata", rq.pop_front(), {rr, rd});
        if (bv && bry) chk("bresp", wq.pop_front(), br);
    end

    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rdc(OFS_MAIN, RST_MAIN);
        rdc(OFS_FT, RST_FT);
        wr(OFS_REFS, 8'h3A);
        rdc(OFS_REFS, 8'h3A);
        chk("vref", 2'b11, vref);
        chk("pcfg", 4'hA, pcfg);
        wr(8'h18, 8'h55, RESP_SLVERR);
        rdc(8'h18, 8'h00, RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            vin <= rnd[9:0];
            ch = rnd[13:10];
            q = 3'(i + 3);
            c = 3'(i);
            slp <= (c[1:0] == 2'b11);
            ft = {c[0], 1'b1, q, c};
            wr(OFS_FT, ft);
            rdc(OFS_FT, ft & 8'hBF);
            wr(OFS_MAIN, {2'b00, ch, 2'b01});
            chk("channel", ch, chn);
            wr(OFS_MAIN, {2'b00, ch, 2'b11});
            wdone();
            t = (c[1:0] == 2'b11 ? TCY_CYC : 0) + (acq[q] + CONV_TADS) * per[c];
            chk("conv_time", 1'b1, n >= t - 2 && n <= t + 2);
            chk("sample_gap", 1'b0, smp);
            repeat (2 * per[c] + 3) @(posedge clk);
            chk("sample_resume", 1'b1, smp);
            eh = c[0] ? {6'h00, vin[9:8]} : vin[9:2];
            el = c[0] ? vin[7:0] : {vin[1:0], 6'h00};
            rdc(OFS_MAIN, {2'b00, ch, 2'b01});
            rdc(OFS_RES_H, eh);
            rdc(OFS_RES_L, el);
            rdc(OFS_FLAG, 8'h01);
            wr(OFS_FLAG, 8'h01);
            rdc(OFS_FLAG, 8'h00);
        end
        slp <= 1'b0;
        wr(OFS_FT, 8'h8E);
        wr(OFS_MAIN, {2'b00, ch, 2'b11});
        repeat (40) @(posedge clk);
        rdc(OFS_MAIN, {2'b00, ch, 2'b11});
        repeat (300) @(posedge clk);
        wr(OFS_MAIN, {2'b00, ch, 2'b01});
        repeat (200) @(posedge clk);
        rdc(OFS_RES_H, eh);
        rdc(OFS_RES_L, el);
        rdc(OFS_FLAG, 8'h00);
        wr(OFS_MAIN, 8'h00);
        pulse();
        repeat (20) @(posedge clk);
        rdc(OFS_MAIN, 8'h00);
        wr(OFS_MAIN, 8'h01);
        pulse();
        wdone();
        chk("trig_done", 1'b1, done);
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rdc(OFS_MAIN, 8'h00);
        chk("flag_rst", 1'b0, done);
        rdc(OFS_RES_H, eh);
        rdc(OFS_RES_L, el);
        wr(OFS_RES_L, 8'hC3);
        rdc(OFS_RES_L, 8'hC3);
        wrap_up();
    end
endmodule
